// file: hdl/phy_id_autoneg_ability_regs.sv
// Identity words one and two, local advertisement and partner ability registers.
// Assumes a management frame engine giving one-cycle rd/wr requests, synchronous to mclk_i.
`timescale 1ns/1ps
module phy_id_autoneg_ability_regs #(
  parameter logic [15:0] ID_ONE = phy_regs_pkg::ID_ONE_DFLT, // arbitrary value
  parameter logic [5:0]  OUI_HI = phy_regs_pkg::OUI_HI_DFLT, // arbitrary value
  parameter logic [5:0]  MODEL  = phy_regs_pkg::MODEL_DFLT,  // arbitrary value
  parameter logic [3:0]  REV    = phy_regs_pkg::REV_DFLT     // arbitrary value
) (
  input  wire logic                             mclk_i,
  input  wire logic                             sys_rst_i,
  input  wire phy_regs_pkg::mgmt_req_t          mgmt_req_i,
  input  wire logic                             page_load_i,
  input  wire logic                             page_clear_i,
  input  wire logic [phy_regs_pkg::REG_W-1:0]   page_i,
  output logic      [phy_regs_pkg::REG_W-1:0]   mgmt_rdata_o,
  output logic                                  mgmt_rvalid_o,
  output logic      [phy_regs_pkg::REG_W-1:0]   adv_word_o,
  output logic      [phy_regs_pkg::REG_W-1:0]   partner_word_o
);
  import phy_regs_pkg::*;

  bank_state_t        st_r;
  bank_state_t        st_nxt;
  logic [REG_W-1:0]   partner;
  logic [REG_W-1:0]   id_two;

  assign id_two = {OUI_HI, MODEL, REV};

  // Partner page held in its own latch
  partner_page_latch u_partner (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (page_load_i),
    .clear_i   (page_clear_i),
    .page_i    (page_i),
    .ability_o (partner)
  );

  // Read decode; unmapped addresses read zero
  function automatic logic [REG_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
                                                input logic [REG_W-1:0]  adv,
                                                input logic [REG_W-1:0]  ptn,
                                                input logic [REG_W-1:0]  idt);
    logic [REG_W-1:0] v;
    v = READ_ZERO;
    unique case (a)
      ADDR_ID_ONE:  v = ID_ONE;
      ADDR_ID_TWO:  v = idt;
      ADDR_ADV:     v = adv;
      ADDR_PARTNER: v = ptn;
      default:      v = READ_ZERO;
    endcase
    return v;
  endfunction : read_mux

  // Next state of the bank
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = mgmt_req_i.rd;
    if (mgmt_req_i.rd) begin
      st_nxt.rdata = read_mux(mgmt_req_i.addr, st_r.adv, partner, id_two);
    end
    // only writable bits take the write
    if (mgmt_req_i.wr && mgmt_req_i.addr == ADDR_ADV) begin
      // constant bits kept from the fixed pattern
      st_nxt.adv = (mgmt_req_i.wdata & ADV_WR_MASK) | (ADV_RESET & ~ADV_WR_MASK);
    end
    // writes to identity and partner words fall through untouched
    // Partner copy taken again so the output is a flop of this module
    st_nxt.partner = partner;
  end

  // Registered bank; reset loads advertisement defaults
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_r.adv    <= ADV_RESET;
      st_r.rdata  <= READ_ZERO;
      st_r.rvalid <= 1'b0;
      st_r.partner <= PARTNER_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mgmt_rdata_o   = st_r.rdata;
  assign mgmt_rvalid_o  = st_r.rvalid;
  assign adv_word_o     = st_r.adv;
  assign partner_word_o = st_r.partner;

  // Checks run on the management clock; reset cancels attempts in flight
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // Request shapes seen on the management port
  sequence seq_rd_id_two;
    mgmt_req_i.rd && mgmt_req_i.addr == ADDR_ID_TWO;
  endsequence
  sequence seq_rd_partner;
    mgmt_req_i.rd && mgmt_req_i.addr == ADDR_PARTNER;
  endsequence
  sequence seq_wr_adv;
    mgmt_req_i.wr && mgmt_req_i.addr == ADDR_ADV;
  endsequence
  sequence seq_rd_adv;
    mgmt_req_i.rd && mgmt_req_i.addr == ADDR_ADV;
  endsequence
  sequence seq_rd_unmapped;
    mgmt_req_i.rd && mgmt_req_i.addr != ADDR_ID_ONE && mgmt_req_i.addr != ADDR_ID_TWO &&
    mgmt_req_i.addr != ADDR_ADV && mgmt_req_i.addr != ADDR_PARTNER;
  endsequence
  // Page port shapes; the partner word lags a load by two edges
  sequence seq_page_in;
    page_load_i;
  endsequence
  sequence seq_clear_only;
    page_clear_i && !page_load_i;
  endsequence

  chk_rev_readback: assert property (
    seq_rd_id_two |=> mgmt_rvalid_o && mgmt_rdata_o[3:0] == REV)
    else $error("revision field wrong on read");
  chk_oui_model_read: assert property (
    seq_rd_id_two |=> mgmt_rdata_o[15:4] == {OUI_HI, MODEL})
    else $error("identifier or model field wrong on read");
  chk_next_page_wr: assert property (
    seq_wr_adv |=> adv_word_o[BIT_NEXT_PAGE] == $past(mgmt_req_i.wdata[BIT_NEXT_PAGE]))
    else $error("next page bit did not take write");
  chk_fault_adv_wr: assert property (
    seq_wr_adv |=> adv_word_o[BIT_FAULT] == $past(mgmt_req_i.wdata[BIT_FAULT]))
    else $error("local fault bit did not take write");
  chk_ability_wr: assert property (
    seq_wr_adv |=> adv_word_o[8:5] == $past(mgmt_req_i.wdata[8:5]))
    else $error("ability bits did not take write");
  chk_t4_zero: assert property (
    !adv_word_o[BIT_T4] && !partner_word_o[BIT_T4])
    else $error("four-pair ability bit not zero");
  chk_selector_fixed: assert property (
    adv_word_o[SELECTOR_MSB:SELECTOR_LSB] == SELECTOR_STD)
    else $error("local selector field changed");
  chk_reserved_zero: assert property (
    ((adv_word_o & ADV_RSVD_MASK) == READ_ZERO) &&
    ((partner_word_o & PARTNER_RSVD_MASK) == READ_ZERO))
    else $error("reserved bits not zero");
  chk_partner_ability: assert property (
    seq_page_in |=> ##1 partner_word_o[8:5] == $past(page_i[8:5], 2))
    else $error("partner ability not loaded");
  chk_partner_flags: assert property (
    seq_page_in |=> ##1 partner_word_o[15:13] == $past(page_i[15:13], 2))
    else $error("partner flags not loaded");
  chk_partner_read: assert property (
    seq_rd_partner |=> mgmt_rdata_o == $past(partner))
    else $error("partner read value wrong");
  chk_tx_half_bit: assert property (
    seq_wr_adv |=> adv_word_o[BIT_TX_HD] == $past(mgmt_req_i.wdata[BIT_TX_HD]))
    else $error("100 half duplex bit did not take write");
  chk_partner_ro: assert property (
    mgmt_req_i.wr && !page_load_i && !page_clear_i |=> $stable(partner))
    else $error("management write changed partner word");
  chk_partner_select: assert property (
    seq_page_in |=> ##1
    partner_word_o[SELECTOR_MSB:SELECTOR_LSB] == $past(page_i[SELECTOR_MSB:SELECTOR_LSB], 2))
    else $error("partner selector not loaded");
  chk_partner_clear: assert property (
    seq_clear_only |=> ##1 partner_word_o == PARTNER_RESET)
    else $error("partner word not cleared");
  chk_partner_hold: assert property (
    !page_load_i && !page_clear_i |=> $stable(partner))
    else $error("partner word changed without a page");
  chk_adv_fixed_bits: assert property (
    seq_wr_adv |=> (adv_word_o & ~ADV_WR_MASK) == (ADV_RESET & ~ADV_WR_MASK))
    else $error("fixed advertisement bits took a write");
  chk_adv_hold: assert property (
    !(mgmt_req_i.wr && mgmt_req_i.addr == ADDR_ADV) |=> $stable(adv_word_o))
    else $error("advertisement word changed without a write");
  chk_adv_read: assert property (
    seq_rd_adv |=> mgmt_rdata_o == $past(adv_word_o))
    else $error("advertisement read value wrong");
  chk_unmapped_zero: assert property (
    seq_rd_unmapped |=> mgmt_rdata_o == READ_ZERO)
    else $error("unmapped read not zero");
  chk_rvalid_pulse: assert property (
    mgmt_req_i.rd |=> mgmt_rvalid_o)
    else $error("read not answered next cycle");
  chk_rvalid_idle: assert property (
    !mgmt_req_i.rd |=> !mgmt_rvalid_o)
    else $error("read answer without a request");
  chk_rdata_hold: assert property (
    !mgmt_req_i.rd |=> $stable(mgmt_rdata_o))
    else $error("read data changed without a read");

endmodule : phy_id_autoneg_ability_regs

// file: hdl/phy_regs_pkg.sv
// Shared constants and carrier types for the identity and advertisement register group.
// Assumes a management frame engine that presents one decoded 16-bit access per request.
package phy_regs_pkg;

  localparam int unsigned REG_W  = 16;
  localparam int unsigned ADDR_W = 5;

  // Register addresses on the management bus
  localparam logic [4:0] ADDR_ID_ONE  = 5'h02;
  localparam logic [4:0] ADDR_ID_TWO  = 5'h03;
  localparam logic [4:0] ADDR_ADV     = 5'h04;
  localparam logic [4:0] ADDR_PARTNER = 5'h05;

  // Field positions shared by the advertisement and partner words
  localparam int unsigned BIT_NEXT_PAGE = 15;
  localparam int unsigned BIT_ACK       = 14;
  localparam int unsigned BIT_FAULT     = 13;
  localparam int unsigned BIT_T4        = 9;
  localparam int unsigned BIT_TX_FD     = 8;
  localparam int unsigned BIT_TX_HD     = 7;
  localparam int unsigned BIT_10_FD     = 6;
  localparam int unsigned BIT_10_HD     = 5;
  localparam int unsigned SELECTOR_MSB  = 4;
  localparam int unsigned SELECTOR_LSB  = 0;

  // Advertisement word: writable bits, reset value, selector default
  localparam logic [15:0] ADV_WR_MASK   = 16'hA1E0;
  localparam logic [15:0] ADV_RESET     = 16'h01E1;
  localparam logic [4:0]  SELECTOR_STD  = 5'h01;
  localparam logic [15:0] ADV_RSVD_MASK = 16'h5E00;

  // Partner word: bits loaded from a received page, reset value
  localparam logic [15:0] PARTNER_LOAD_MASK = 16'hE1FF;
  localparam logic [15:0] PARTNER_RESET     = 16'h0000;
  localparam logic [15:0] PARTNER_RSVD_MASK = 16'h1E00;

  // Identity defaults; all values arbitrary
  localparam logic [15:0] ID_ONE_DFLT  = 16'h1234;
  localparam logic [5:0]  OUI_HI_DFLT  = 6'h2A;
  localparam logic [5:0]  MODEL_DFLT   = 6'h15;
  localparam logic [3:0]  REV_DFLT     = 4'h3;

  localparam logic [15:0] READ_ZERO = 16'h0000;

  // One management access
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
  } mgmt_req_t;

  // State of the register bank
  typedef struct packed {
    logic [REG_W-1:0] adv;
    logic [REG_W-1:0] rdata;
    logic             rvalid;
    logic [REG_W-1:0] partner;
  } bank_state_t;

  // State of the partner page latch
  typedef struct packed {
    logic [REG_W-1:0] ability;
  } partner_state_t;

endpackage : phy_regs_pkg

// file: hdl/partner_page_latch.sv
// Holds the link partner's base page as seen by management.
// Assumes the negotiation engine pulses load_i with the received page on page_i.
`timescale 1ns/1ps
module partner_page_latch (
  input  wire logic                     mclk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     load_i,
  input  wire logic                     clear_i,
  input  wire logic [phy_regs_pkg::REG_W-1:0] page_i,
  output logic      [phy_regs_pkg::REG_W-1:0] ability_o
);
  import phy_regs_pkg::*;

  partner_state_t st_r;
  partner_state_t st_nxt;

  // Load wins over clear so a page arriving during restart is kept
  always_comb begin
    st_nxt = st_r;
    if (clear_i) begin
      st_nxt.ability = PARTNER_RESET;
    end
    if (load_i) begin
      // T4 and reserved bits never latched
      st_nxt.ability = page_i & PARTNER_LOAD_MASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_r.ability <= PARTNER_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ability_o = st_r.ability;

endmodule : partner_page_latch

// file: dv/sta_model.sv
// Station management controller model issuing single-word reads and writes.
// Assumes the bank answers a read with a one-cycle valid pulse a cycle later.
`timescale 1ns/1ps
module sta_model (
  input  wire logic                    mclk_i,
  input  wire logic                    rvalid_i,
  input  wire logic [15:0]             rdata_i,
  output phy_regs_pkg::mgmt_req_t      req_o
);
  import phy_regs_pkg::*;
  initial req_o = '0;
  // One-cycle write pulse, launched on the falling edge
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge mclk_i);
    req_o = '0;
  endtask : write_reg
  // Read pulse; bounded wait so a dead bank cannot hang the run
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(negedge mclk_i);
    req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge mclk_i);
      req_o = '0;
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = rdata_i;
      end
    end
  endtask : read_reg
endmodule : sta_model

// file: dv/phy_id_autoneg_ability_regs_tb_top.sv
// Self-checking bench for the identity and advertisement register group.
// Assumes sta_model as management master; the bench plays the page source.
`timescale 1ns/1ps
module phy_id_autoneg_ability_regs_tb_top;
  import phy_regs_pkg::*;
  logic        mclk_i       = 1'b0;
  logic        sys_rst_i    = 1'b1;
  logic        page_load_i  = 1'b0;
  logic        page_clear_i = 1'b0;
  logic [15:0] page_i       = 16'h0000;
  mgmt_req_t   req;
  logic [15:0] rdata, adv_w, ptn_w, rd_v, d, p;
  logic        rvalid, ok;
  int          error_cnt = 0;
  int          compares  = 0;
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  sta_model u_sta (.mclk_i(mclk_i), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));
  phy_id_autoneg_ability_regs DUT (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .mgmt_req_i(req), .page_load_i(page_load_i),
    .page_clear_i(page_clear_i), .page_i(page_i), .mgmt_rdata_o(rdata),
    .mgmt_rvalid_o(rvalid), .adv_word_o(adv_w), .partner_word_o(ptn_w));
  // Only next page, fault and the four abilities stick; selector stays one
  function automatic logic [15:0] exp_adv(input logic [15:0] w);
    return (w & 16'hA1E0) | 16'h0001;
  endfunction : exp_adv
  // Reserved and four-pair bits never reach the partner word
  function automatic logic [15:0] exp_ptn(input logic [15:0] w);
    return w & 16'hE1FF;
  endfunction : exp_ptn
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp16
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    u_sta.read_reg(a, rd_v, ok);
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t no read answer", $time);
      print_verdict();
    end else begin
      cmp16(rd_v, exp);
    end
  endtask : rd_chk
  task automatic load_page(input logic [15:0] w, input logic clr);
    @(negedge mclk_i);
    page_i = w;
    page_load_i = 1'b1;
    page_clear_i = clr;
    @(negedge mclk_i);
    page_load_i = 1'b0;
    page_clear_i = 1'b0;
  endtask : load_page
  // Main sequence: reset values, random traffic, then clear
  initial begin
    void'($urandom(32'h366a));
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    cmp16(adv_w, 16'h01E1);
    cmp16(ptn_w, 16'h0000);
    rd_chk(ADDR_ID_TWO, {OUI_HI_DFLT, MODEL_DFLT, REV_DFLT});
    rd_chk(ADDR_ID_ONE, ID_ONE_DFLT);
    rd_chk(ADDR_ADV, 16'h01E1);
    rd_chk(ADDR_PARTNER, 16'h0000);
    rd_chk(5'h1F, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      p = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      u_sta.write_reg(ADDR_ADV, d);
      cmp16(adv_w, exp_adv(d));
      rd_chk(ADDR_ADV, exp_adv(d));
      u_sta.write_reg(ADDR_ID_TWO, ~d);
      rd_chk(ADDR_ID_TWO, {OUI_HI_DFLT, MODEL_DFLT, REV_DFLT});
      load_page(p, 1'b0);
      rd_chk(ADDR_PARTNER, exp_ptn(p));
      cmp16(ptn_w, exp_ptn(p));
      u_sta.write_reg(ADDR_PARTNER, ~p);
      rd_chk(ADDR_PARTNER, exp_ptn(p));
    end
    load_page(16'hFFFF, 1'b1);
    rd_chk(ADDR_PARTNER, 16'hE1FF);
    @(negedge mclk_i);
    page_clear_i = 1'b1;
    @(negedge mclk_i);
    page_clear_i = 1'b0;
    rd_chk(ADDR_PARTNER, 16'h0000);
    // Second reset after traffic; every word must fall back to its default
    u_sta.write_reg(ADDR_ADV, 16'h0000);
    load_page(16'hFFFF, 1'b0);
    @(negedge mclk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    cmp16(adv_w, 16'h01E1);
    cmp16(ptn_w, 16'h0000);
    cmp16(rdata, 16'h0000);
    rd_chk(ADDR_ADV, 16'h01E1);
    rd_chk(ADDR_PARTNER, 16'h0000);
    print_verdict();
  end
endmodule : phy_id_autoneg_ability_regs_tb_top
